//--- cjio_pkg.sv
package cjio_pkg;

    // Operation codes handed in by the surrounding decode
    typedef enum logic [2:0] {
        CJIO_OP_NONE,
        CJIO_OP_JUMP_NEAR,
        CJIO_OP_JUMP_FAR,
        CJIO_OP_ADD_ONE,
        CJIO_OP_ADD_TWO,
        CJIO_OP_OR
    } cjio_op_type;

    // Operand/issue bundle
    typedef struct packed {
        logic        valid;
        cjio_op_type op;
        logic        size_byte;   // Encoding size bit: 0 word, 1 byte
        logic [3:0]  src_reg;     // Working register index for jumps
        logic [15:0] opa;         // Source operand (f or Ws)
        logic [15:0] opb;         // Default working register value for OR
    } cjio_req_type;

    // Flag bundle
    typedef struct packed {
        logic dc;
        logic n;
        logic ov;
        logic z;
        logic c;
    } cjio_flags_type;

    localparam int          CJIO_PC_W         = 24;
    localparam logic [23:0] CJIO_PC_RST       = 24'h000000;
    localparam int          CJIO_FAR_HI_LSB   = 16;
    localparam int          CJIO_FAR_HI_W     = 7;
    localparam logic [3:0]  CJIO_FAR_MAX_REG  = 4'hc;
    localparam logic [15:0] CJIO_RES_RST      = 16'h0000;
    localparam logic [15:0] CJIO_INC_ONE      = 16'h0001;
    localparam logic [15:0] CJIO_INC_TWO      = 16'h0002;

endpackage : cjio_pkg

//--- cjio_alu.sv
`timescale 1ns/1ns
`default_nettype none

// Combinational add and OR datapath with byte/word flag generation
module cjio_alu
    import cjio_pkg::*;
(
    input  wire logic [15:0]    opa,
    input  wire logic [15:0]    addend,
    input  wire logic [15:0]    opb,
    input  wire logic           do_or,
    input  wire logic           size_byte,
    output logic [15:0]         result,
    output cjio_flags_type      flags
);

    logic [16:0] sum;
    logic [4:0]  nib;
    logic [15:0] raw;
    logic        msb_a;
    logic        msb_b;
    logic        msb_r;

    // Sum, OR and flags computed for both sizes; byte mode keeps upper byte of opa
    always_comb begin
        sum   = {1'b0, opa} + {1'b0, addend};
        nib   = {1'b0, opa[3:0]} + {1'b0, addend[3:0]};
        raw   = do_or ? (opa | opb) : sum[15:0];
        flags = '0;
        if (size_byte) begin
            result = {opa[15:8], raw[7:0]};
            msb_a  = opa[7];
            msb_b  = do_or ? opb[7] : addend[7];
            msb_r  = raw[7];
            flags.z = (raw[7:0] == 8'h00);
            flags.c = (({1'b0, opa[7:0]} + {1'b0, addend[7:0]}) > 9'h0ff);
        end else begin
            result = raw;
            msb_a  = opa[15];
            msb_b  = do_or ? opb[15] : addend[15];
            msb_r  = raw[15];
            flags.z = (raw == 16'h0000);
            flags.c = sum[16];
        end
        flags.n  = msb_r;
        flags.dc = nib[4];
        flags.ov = (msb_a == msb_b) && (msb_r != msb_a);
    end

endmodule : cjio_alu

`default_nettype wire

//--- cjio_exec.sv
`timescale 1ns/1ns
`default_nettype none

// Summary of operation
// - The far jump accepts only even working registers zero to twelve as its source.
// - The far jump loads PC 22:16 from the partner's low seven bits and PC 15:1 from the source, clearing PC 0.
// - The far jump leaves PC bit 23 unchanged.
// - Partner register bits 15 to 7 never affect the far jump target.
// - Byte suffix selects byte operands, otherwise word operands are used.
// - Add-one writes source plus one to the destination.
// - Add-two writes source plus two to the destination in the selected size.
// - The size bit selects word when zero and byte when one.
module cjio_exec
    import cjio_pkg::*;
(
    input  wire logic           ref_clk,
    input  wire logic           arst_n,
    input  wire cjio_req_type   req,
    input  wire logic [15:0]    work_src,      // Working register selected by src_reg
    input  wire logic [15:0]    work_pair,     // Next odd working register
    input  wire cjio_flags_type flags_in,
    output logic [23:0]         pc_q,
    output logic                pc_load_q,
    output logic [15:0]         result_q,
    output logic                result_we_q,
    output cjio_flags_type      flags_q,
    output logic                flags_we_q,
    output logic                illegal_q
);

    ////////////////////////////////////////////////////////////////////////
    // Source register check for the far jump

    // Even index up to twelve, so the odd partner is still a real register
    function automatic logic far_src_ok(input logic [3:0] r);
        far_src_ok = (r[0] == 1'b0) && (r <= CJIO_FAR_MAX_REG);
    endfunction : far_src_ok

    ////////////////////////////////////////////////////////////////////////
    // Datapath

    logic [15:0]    addend;
    logic [15:0]    alu_res;
    cjio_flags_type alu_flags;
    logic           is_or;

    // Add-one or add-two picks the constant addend. The adder runs on every
    // cycle whatever the op; only the groups below decide whether its value
    // and flags are kept, which keeps the decode out of the carry path.
    assign is_or  = (req.op == CJIO_OP_OR);
    assign addend = (req.op == CJIO_OP_ADD_TWO) ? CJIO_INC_TWO : CJIO_INC_ONE;

    // Size comes straight from the encoding bit; in byte size the upper
    // byte of the source passes through unchanged
    cjio_alu u_alu (
        .opa       (req.opa),
        .addend    (addend),
        .opb       (req.opb),
        .do_or     (is_or),
        .size_byte (req.size_byte),
        .result    (alu_res),
        .flags     (alu_flags)
    );

    ////////////////////////////////////////////////////////////////////////
    // Program counter, result and flag registers
    //
    // The state splits into three groups that never share a write: the
    // jump group owns the PC, the result group owns the destination value
    // and the flag group owns the status bits. Each group has one next-value
    // process and one register process, so a change in one op class cannot
    // disturb the strobes of another. The illegal strobe lives with the PC
    // because only a jump can be refused here; undefined op codes are folded
    // into the same pulse.

    ////////////////////////////////////////////////////////////////////////
    // Op class decode, shared by the result and flag groups

    // Both adders update the full flag set and write a destination;
    // they differ only in the constant handed to the adder
    function automatic logic op_is_add(input cjio_op_type op);
        op_is_add = (op == CJIO_OP_ADD_ONE) || (op == CJIO_OP_ADD_TWO);
    endfunction : op_is_add

    // Every op that produces a value for the destination operand; jumps
    // and idle cycles leave result_q alone
    function automatic logic op_writes_dest(input cjio_op_type op);
        op_writes_dest = op_is_add(op) || (op == CJIO_OP_OR);
    endfunction : op_writes_dest

    ////////////////////////////////////////////////////////////////////////
    // Jump group

    logic [23:0]    near_target;
    logic [23:0]    far_target;
    logic [23:0]    pc_d;
    logic           pc_load_d;
    logic           illegal_d;

    // Near form clears the page bits, so it only reaches the bottom 64K
    assign near_target = {8'h00, work_src[15:1], 1'b0};

    // Far form keeps the top bit and takes seven page bits from the pair;
    // the pair's bits 15:7 are dropped here and bit 0 of the source is
    // ignored because the PC always sits on an even address
    assign far_target = {pc_q[23],
                         work_pair[CJIO_FAR_HI_W-1:0],
                         work_src[15:1], 1'b0};

    // Next PC; a refused far jump raises illegal and leaves the PC alone.
    // Only one jump issues per cycle, so the two targets never compete.
    always_comb begin
        pc_d      = pc_q;
        pc_load_d = 1'b0;
        illegal_d = 1'b0;
        if (req.valid) begin
            unique case (req.op)
                CJIO_OP_JUMP_NEAR: begin
                    pc_d      = near_target;
                    pc_load_d = 1'b1;
                end
                CJIO_OP_JUMP_FAR: begin
                    // Odd source would alias the pair, so it traps instead
                    if (far_src_ok(req.src_reg)) begin
                        pc_d      = far_target;
                        pc_load_d = 1'b1;
                    end else begin
                        illegal_d = 1'b1;
                    end
                end
                CJIO_OP_NONE,
                CJIO_OP_ADD_ONE,
                CJIO_OP_ADD_TWO,
                CJIO_OP_OR: begin
                    // Not a jump; the PC holds and no strobe rises
                    pc_load_d = 1'b0;
                end
                default: begin
                    // Codes outside the enum are refused like a bad far source
                    illegal_d = 1'b1;
                end
            endcase
        end
    end

    // Jump group registers; pc_q is the copy the core reloads from
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            pc_q      <= CJIO_PC_RST;
            pc_load_q <= 1'b0;
            illegal_q <= 1'b0;
        end else begin
            pc_q      <= pc_d;
            pc_load_q <= pc_load_d;
            illegal_q <= illegal_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Result group

    logic [15:0]    result_d;
    logic           result_we_d;

    // Adders and OR hand their ALU value to the destination write;
    // the core routes result_q to the register or memory operand
    always_comb begin
        result_d    = result_q;
        result_we_d = 1'b0;
        if (req.valid && op_writes_dest(req.op)) begin
            result_d    = alu_res;
            result_we_d = 1'b1;
        end
    end

    // Result group registers; result_q holds between writes
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            result_q    <= CJIO_RES_RST;
            result_we_q <= 1'b0;
        end else begin
            result_q    <= result_d;
            result_we_q <= result_we_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Flag group

    cjio_flags_type flags_d;
    logic           flags_we_d;

    // Adders replace all five flags; OR only touches N and Z and passes
    // the rest through from the core, so jumps and idle cycles write none
    always_comb begin
        flags_d    = flags_q;
        flags_we_d = 1'b0;
        if (req.valid && op_is_add(req.op)) begin
            flags_d    = alu_flags;
            flags_we_d = 1'b1;
        end else if (req.valid && (req.op == CJIO_OP_OR)) begin
            flags_d    = flags_in;
            flags_d.n  = alu_flags.n;
            flags_d.z  = alu_flags.z;
            flags_we_d = 1'b1;
        end
    end

    // Flags clear on reset; the core keeps its own copy of the status bits
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            flags_q    <= '0;
            flags_we_q <= 1'b0;
        end else begin
            flags_q    <= flags_d;
            flags_we_q <= flags_we_d;
        end
    end

endmodule : cjio_exec

`default_nettype wire

//--- cjio_exec_assertions.sv
`timescale 1ns/1ns
`default_nettype none
// Watches the executor ports; every answer lands one edge after its request
module cjio_exec_chk
    import cjio_pkg::*;
(
    input wire logic           ref_clk,
    input wire logic           arst_n,
    input wire cjio_req_type   req,
    input wire logic [15:0]    work_src,
    input wire logic [15:0]    work_pair,
    input wire cjio_flags_type flags_in,
    input wire logic [23:0]    pc_q,
    input wire logic           pc_load_q,
    input wire logic [15:0]    result_q,
    input wire logic           result_we_q,
    input wire cjio_flags_type flags_q,
    input wire logic           flags_we_q,
    input wire logic           illegal_q
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    logic far_ok;
    ////////////////////////////////////////////////////////////////////////////////
    // Source must be even and at most twelve, since its odd partner is read too
    assign far_ok = !req.src_reg[0] && (req.src_reg <= CJIO_FAR_MAX_REG);
    sequence far_s;
        req.valid && req.op == CJIO_OP_JUMP_FAR;
    endsequence
    sequence far_ok_s;
        far_s ##0 far_ok;
    endsequence
    far_bad_a: assert property (far_s ##0 !far_ok |=> illegal_q && !pc_load_q && $stable(pc_q))
        else $error("bad far source was taken");
    far_pc_a: assert property (far_ok_s |=> pc_load_q &&
        pc_q[22:0] == {$past(work_pair[6:0]), $past(work_src[15:1]), 1'b0})
        else $error("far jump target wrong");
    far_top_a: assert property (far_ok_s |=> pc_q[23] == $past(pc_q[23]))
        else $error("far jump changed top pc bit");
    ////////////////////////////////////////////////////////////////////////////////
    // Arithmetic and logic results
    add_one_a: assert property (req.valid && req.op == CJIO_OP_ADD_ONE && !req.size_byte
        |=> result_we_q && result_q == $past(req.opa) + 16'h0001) else $error("add one wrong");
    add_two_a: assert property (req.valid && req.op == CJIO_OP_ADD_TWO && !req.size_byte
        |=> result_we_q && result_q == $past(req.opa) + 16'h0002) else $error("add two wrong");
    add_flag_a: assert property (req.valid && !req.size_byte && req.op inside {CJIO_OP_ADD_ONE,
        CJIO_OP_ADD_TWO} |=> flags_we_q && flags_q.n == result_q[15] &&
        flags_q.z == (result_q == 16'h0000)) else $error("add flags wrong");
    byte_hi_a: assert property (req.valid && req.size_byte && req.op inside {CJIO_OP_ADD_ONE,
        CJIO_OP_ADD_TWO, CJIO_OP_OR} |=> result_q[15:8] == $past(req.opa[15:8]))
        else $error("byte op touched high byte");
    or_keep_a: assert property (req.valid && req.op == CJIO_OP_OR |=> flags_we_q &&
        result_q[7:0] == $past(req.opa[7:0] | req.opb[7:0]) &&
        {flags_q.dc, flags_q.ov, flags_q.c} == $past({flags_in.dc, flags_in.ov, flags_in.c}))
        else $error("or result or kept flags wrong");
    jump_flag_a: assert property (req.valid && req.op inside {CJIO_OP_JUMP_NEAR,
        CJIO_OP_JUMP_FAR} |=> !flags_we_q && !result_we_q) else $error("jump wrote flags");
    idle_a: assert property (!req.valid || req.op == CJIO_OP_NONE
        |=> !pc_load_q && !result_we_q && !flags_we_q && !illegal_q) else $error("idle pulse");
endmodule : cjio_exec_chk
bind cjio_exec cjio_exec_chk chk_u (.ref_clk(ref_clk), .arst_n(arst_n), .req(req),
    .work_src(work_src), .work_pair(work_pair), .flags_in(flags_in), .pc_q(pc_q),
    .pc_load_q(pc_load_q), .result_q(result_q), .result_we_q(result_we_q),
    .flags_q(flags_q), .flags_we_q(flags_we_q), .illegal_q(illegal_q));
`default_nettype wire

//--- cjio_exec_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module cjio_exec_tb_top;
    import cjio_pkg::*;
    logic           ref_clk = 1'b0;
    logic           arst_n = 1'b0;
    cjio_req_type   req = '0;
    logic [15:0]    work_src = '0;
    logic [15:0]    work_pair = '0;
    cjio_flags_type flags_in = '0;
    logic [23:0]    pc_q;
    logic [15:0]    result_q;
    logic           pc_load_q, result_we_q, flags_we_q, illegal_q;
    cjio_flags_type flags_q;
    int             fail_count = 0, n_tests = 0, cyc = 0;
    cjio_exec dut_u (.ref_clk(ref_clk), .arst_n(arst_n), .req(req), .work_src(work_src),
        .work_pair(work_pair), .flags_in(flags_in), .pc_q(pc_q), .pc_load_q(pc_load_q),
        .result_q(result_q), .result_we_q(result_we_q), .flags_q(flags_q),
        .flags_we_q(flags_we_q), .illegal_q(illegal_q));
    ////////////////////////////////////////////////////////////////////////////////
    // Clock and a cycle ceiling so a hang still reaches the verdict
    initial forever #4 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 2000) begin
            fail_count++;
            summarize();
        end
    end
    task automatic chk(logic [23:0] got, logic [23:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic summarize();
        $display("checks=%0d mismatches=%0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : summarize
    // One request at a falling edge; outputs are judged one cycle later, when valid drops
    task automatic go(cjio_op_type op, logic sb, logic [3:0] sr, logic [15:0] a, b, ws, wp);
        @(negedge ref_clk);
        req = '{1'b1, op, sb, sr, a, b};
        work_src = ws;
        work_pair = wp;
        @(negedge ref_clk);
        req.valid = 1'b0;
    endtask : go
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_far();
        go(CJIO_OP_JUMP_FAR, 1'b0, 4'h4, 16'h0000, 16'h0000, 16'h6845, 16'hff82);
        chk(pc_q, 24'h026844);
        chk(24'(flags_we_q), 24'h000000);
        for (int i = 0; i < 2; i++) begin
            go(CJIO_OP_JUMP_FAR, 1'b0, i ? 4'he : 4'h1, 16'h0, 16'h0, 16'h1234, 16'h0055);
            chk(24'(illegal_q), 24'h000001);
            chk(pc_q, 24'h026844);
        end
        go(CJIO_OP_JUMP_FAR, 1'b0, 4'hc, 16'h0000, 16'h0000, 16'h1111, 16'h0080);
        chk(pc_q, 24'h001110);
        chk(24'(pc_load_q), 24'h000001);
    endtask : t_far
    task automatic t_add();
        go(CJIO_OP_ADD_TWO, 1'b0, 4'h0, 16'hff7f, 16'h0000, 16'h0000, 16'h0000);
        chk(24'(result_q), 24'h00ff81);
        chk(24'(result_we_q), 24'h000001);
        chk(24'(flags_q), 24'h000018);
        chk(24'(flags_we_q), 24'h000001);
        go(CJIO_OP_ADD_ONE, 1'b0, 4'h0, 16'hff7f, 16'h0000, 16'h0000, 16'h0000);
        chk(24'(result_q), 24'h00ff80);
        go(CJIO_OP_ADD_ONE, 1'b1, 4'h0, 16'h8fff, 16'h0000, 16'h0000, 16'h0000);
        chk(24'(result_q), 24'h008f00);
        chk(24'(flags_q.c), 24'h000001);
        go(CJIO_OP_ADD_TWO, 1'b1, 4'h0, 16'hff7f, 16'h0000, 16'h0000, 16'h0000);
        chk(24'(flags_q.ov), 24'h000001);
    endtask : t_add
    task automatic t_or();
        flags_in = 5'h17;
        go(CJIO_OP_OR, 1'b0, 4'h0, 16'haaaa, 16'h5555, 16'h0000, 16'h0000);
        chk(24'(flags_q), 24'h00001d);
        go(CJIO_OP_OR, 1'b1, 4'h0, 16'h1234, 16'h00aa, 16'h0000, 16'h0000);
        chk(24'(result_q), 24'h0012be);
        go(CJIO_OP_OR, 1'b0, 4'h0, 16'h0000, 16'h0000, 16'h0000, 16'h0000);
        chk(24'(flags_q), 24'h000017);
        go(CJIO_OP_JUMP_NEAR, 1'b0, 4'h4, 16'h0000, 16'h0000, 16'h7845, 16'hffff);
        chk(24'(flags_we_q), 24'h000000);
    endtask : t_or
    initial begin
        repeat (4) @(posedge ref_clk);
        @(negedge ref_clk);
        arst_n = 1'b1;
        t_far();
        t_add();
        t_or();
        summarize();
    end
endmodule : cjio_exec_tb_top
`default_nettype wire
